// ==== core/dep_mask_cfg.svh ====
// offsets, field positions, reset values and bus constants of the
// dependency mask block; included by the block and by its bench
`ifndef DEP_MASK_CFG_SVH
`define DEP_MASK_CFG_SVH

// register indices; byte address is four times the index
`define IDX_O4T2_PRI   16'h0020
`define IDX_O4T2_SEC   16'h0021
`define IDX_O4T2_OUT   16'h0022
`define IDX_O4T2_O8    16'h0023
`define IDX_O5T1_PRI   16'h0024
`define IDX_O5T1_SEC   16'h0025
`define IDX_O5T1_OUT   16'h0026
`define IDX_O5T1_O8    16'h002A
`define IDX_MRST_MASK  16'h0040
`define IDX_STATUS     16'h0041
// nonvolatile shadow index is this base ored with the register index
`define NV_BASE        16'h8000

`define NUM_SLOTS      9
`define REG_RESET      8'h00

// field positions
`define MRST_BIT_O4    3
`define MRST_BIT_O5    4
`define O8_BIT_O4      1
`define O8_BIT_O5      0
`define STAT_RUN       0
`define STAT_T42       1
`define STAT_T51       2
`define STAT_OUT4      3
`define STAT_OUT5      4
`define STAT_MRST_LOW  5

// bus decode
`define IDX_LSB        2
`define IDX_MSB        17
`define AHB_SIZE_WORD  3'b010

`endif

// ==== core/dep_mask_pkg.sv ====
// types of the dependency mask block
// assumes nothing beyond a SystemVerilog compiler
package dep_mask_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } seq_state_t;

  typedef enum logic [3:0] {
    SLOT_O4_PRI = 4'h0,
    SLOT_O4_SEC = 4'h1,
    SLOT_O4_OUT = 4'h2,
    SLOT_O4_O8  = 4'h3,
    SLOT_O5_PRI = 4'h4,
    SLOT_O5_SEC = 4'h5,
    SLOT_O5_OUT = 4'h6,
    SLOT_O5_O8  = 4'h7,
    SLOT_MRST   = 4'h8
  } slot_t;

  typedef logic [7:0] mask_byte_t;

endpackage

// ==== core/mask_term.sv ====
// one product term of an output dependency mask
// assumes source bits are high while the source is in fault or asserted
`timescale 1ns/10ps
`default_nettype none

module mask_term #(
  parameter int unsigned WIDTH = 25
) (
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [WIDTH-1:0] src,
  output logic                  term,
  output logic [WIDTH-1:0]      blocking
);

  assign blocking = mask & src;
  // term is 1 only when no selected source is active; empty mask gives 1
  assign term = ~|blocking;

endmodule

`default_nettype wire

// ==== core/output_dependency_masks.sv ====
// dependency masks of prog_output_4 (term 2) and prog_output_5 (term 1)
// assumes an AHB-Lite master on core_clk, a single slave on the bus, and
// fault sources that are high while in fault or asserted
//
// Function
// - reg 20h bits 0-5 tie prog_output_4 term 2 to primary thresholds.
// - reg 20h bits 6-7 tie prog_output_4 term 2 to watchdogs 1, 2.
// - reg 21h bits 0-5 tie prog_output_4 term 2 to secondary thresholds.
// - reg 21h bits 6-7, 22h bits 0-1 select logic inputs 1-4.
// - reg 22h bits 2-7 select outputs 1,2,3,5,6,7 for prog_output_4.
// - reg 23h bit 1 selects prog_output_8 for prog_output_4.
// - reg 40h bit 3 asserts prog_output_4 while manual reset is low.
// - a zero mask bit makes the output ignore that source.
// - prog_output_4 deasserts when either of its product terms is 1, unless reg 40h bit 3 holds it asserted.
// - reg 24h selects primary thresholds and watchdogs for prog_output_5.
// - reg 25h selects secondary thresholds and logic inputs 1-2.
// - reg 26h selects logic inputs 3-4 and outputs 1,2,3,4,6,7.
// - reg 2Ah bit 0 selects prog_output_8 for prog_output_5.
// - reg 40h bit 4 asserts prog_output_5 while manual reset is low.
// - every mask register has a nonvolatile shadow at 8000h plus offset.
// - prog_output_5 deasserts when either of its product terms is 1, unless reg 40h bit 4 holds it asserted.
`timescale 1ns/10ps
`default_nettype none
`include "dep_mask_cfg.svh"

module output_dependency_masks (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        nv_por,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [5:0]  primary_fault,
  input  wire logic [5:0]  secondary_fault,
  input  wire logic [1:0]  watchdog_fault,
  input  wire logic [3:0]  logic_input,
  input  wire logic        manual_reset_n,
  input  wire logic [5:0]  other_output_asserted,
  input  wire logic        prog_output_4_term1,
  input  wire logic        prog_output_5_term2,
  output logic             prog_output_4_asserted,
  output logic             prog_output_5_asserted
);

  localparam logic [15:0] SLOT_IDX [`NUM_SLOTS] = '{
    `IDX_O4T2_PRI, `IDX_O4T2_SEC, `IDX_O4T2_OUT, `IDX_O4T2_O8,
    `IDX_O5T1_PRI, `IDX_O5T1_SEC, `IDX_O5T1_OUT, `IDX_O5T1_O8,
    `IDX_MRST_MASK
  };

  dep_mask_pkg::seq_state_t state_q;
  dep_mask_pkg::mask_byte_t work_q   [`NUM_SLOTS];
  dep_mask_pkg::mask_byte_t shadow_q [`NUM_SLOTS];

  logic [3:0]  li_meta_q;
  logic [3:0]  li_sync_q;
  logic        mrn_meta_q;
  logic        mrn_sync_q;
  logic        wr_pend_q;
  logic        rd_wait_q;
  logic        in_range_q;
  logic [15:0] idx_q;
  logic [31:0] hrdata_q;
  logic        out4_q;
  logic        out5_q;
  logic        out4_d;
  logic        out5_d;

  logic [`NUM_SLOTS-1:0] hit_work;
  logic [`NUM_SLOTS-1:0] hit_nv;
  logic [7:0]            rd_byte;
  logic [7:0]            status_byte;
  logic                  hit_status;
  logic                  run;
  logic                  addr_ok;
  logic                  man_low;
  logic                  man4;
  logic                  man5;
  logic [24:0]           mask4;
  logic [24:0]           mask5;
  logic [24:0]           src4;
  logic [24:0]           src5;
  logic                  t42;
  logic                  t51;

  // logic inputs and manual reset pass two flops before any logic looks at them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      li_meta_q  <= 4'h0;
      li_sync_q  <= 4'h0;
      mrn_meta_q <= 1'b1;
      mrn_sync_q <= 1'b1;
    end else begin
      li_meta_q  <= logic_input;
      li_sync_q  <= li_meta_q;
      mrn_meta_q <= manual_reset_n;
      mrn_sync_q <= mrn_meta_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= dep_mask_pkg::ST_LOAD;
    end else begin
      state_q <= dep_mask_pkg::ST_RUN;
    end
  end

  assign run = (state_q == dep_mask_pkg::ST_RUN);

  // bus stalls during the load and for one cycle of each read
  assign hreadyout = run & ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addr_ok   = hsel & hready & htrans[1] & run;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend_q  <= 1'b0;
      rd_wait_q  <= 1'b0;
      in_range_q <= 1'b0;
      idx_q      <= 16'h0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite & (hsize == `AHB_SIZE_WORD);
      rd_wait_q <= addr_ok & ~hwrite;
      if (addr_ok) begin
        in_range_q <= (haddr[31:`IDX_MSB+1] == 14'h0000);
        idx_q      <= haddr[`IDX_MSB:`IDX_LSB];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // one working register and one shadow per slot
  for (genvar i = 0; i < `NUM_SLOTS; i++) begin : g_slot
    assign hit_work[i] = in_range_q & (idx_q == SLOT_IDX[i]);
    assign hit_nv[i] = in_range_q & (idx_q == (`NV_BASE | SLOT_IDX[i]));

    always_ff @(posedge core_clk) begin
      if (srst) begin
        work_q[i] <= `REG_RESET;
      end else if (state_q == dep_mask_pkg::ST_LOAD) begin
        work_q[i] <= shadow_q[i];
      end else if (wr_pend_q & hit_work[i]) begin
        work_q[i] <= hwdata[7:0];
      end
    end

    // shadow survives srst; only the first power-up clears it
    always_ff @(posedge core_clk) begin
      if (nv_por) begin
        shadow_q[i] <= `REG_RESET;
      end else if (wr_pend_q & hit_nv[i]) begin
        shadow_q[i] <= hwdata[7:0];
      end
    end
  end

  assign hit_status = in_range_q & (idx_q == `IDX_STATUS);

  always_comb begin
    status_byte                 = 8'h00;
    status_byte[`STAT_RUN]      = run;
    status_byte[`STAT_T42]      = t42;
    status_byte[`STAT_T51]      = t51;
    status_byte[`STAT_OUT4]     = out4_q;
    status_byte[`STAT_OUT5]     = out5_q;
    status_byte[`STAT_MRST_LOW] = man_low;
  end

  // unmapped indices read as zero
  always_comb begin
    rd_byte = hit_status ? status_byte : 8'h00;
    for (int k = 0; k < `NUM_SLOTS; k++) begin
      if (hit_work[k]) begin
        rd_byte = rd_byte | work_q[k];
      end
      if (hit_nv[k]) begin
        rd_byte = rd_byte | shadow_q[k];
      end
    end
  end

  assign mask4 = {work_q[dep_mask_pkg::SLOT_O4_O8][`O8_BIT_O4],
                  work_q[dep_mask_pkg::SLOT_O4_OUT],
                  work_q[dep_mask_pkg::SLOT_O4_SEC],
                  work_q[dep_mask_pkg::SLOT_O4_PRI]};
  assign src4  = {other_output_asserted[5:3], out5_q, other_output_asserted[2:0],
                  li_sync_q, secondary_fault, watchdog_fault, primary_fault};

  // secondary and logic inputs 1, 2
  // logic inputs 3, 4 and outputs
  assign mask5 = {work_q[dep_mask_pkg::SLOT_O5_O8][`O8_BIT_O5],
                  work_q[dep_mask_pkg::SLOT_O5_OUT],
                  work_q[dep_mask_pkg::SLOT_O5_SEC],
                  work_q[dep_mask_pkg::SLOT_O5_PRI]};
  assign src5  = {other_output_asserted[5:3], out4_q, other_output_asserted[2:0],
                  li_sync_q, secondary_fault, watchdog_fault, primary_fault};

  mask_term #(
    .WIDTH    (25)
  ) u_term_out4 (
    .mask     (mask4),
    .src      (src4),
    .term     (t42),
    .blocking ()
  );

  mask_term #(
    .WIDTH    (25)
  ) u_term_out5 (
    .mask     (mask5),
    .src      (src5),
    .term     (t51),
    .blocking ()
  );

  assign man_low = ~mrn_sync_q;
  assign man4 = work_q[dep_mask_pkg::SLOT_MRST][`MRST_BIT_O4] & man_low;
  assign man5 = work_q[dep_mask_pkg::SLOT_MRST][`MRST_BIT_O5] & man_low;

  assign out4_d = man4 | ~(prog_output_4_term1 | t42);
  assign out5_d = man5 | ~(t51 | prog_output_5_term2);

  // outputs stay asserted through reset and the mask load
  always_ff @(posedge core_clk) begin
    if (srst | ~run) begin
      out4_q <= 1'b1;
      out5_q <= 1'b1;
    end else begin
      out4_q <= out4_d;
      out5_q <= out5_d;
    end
  end

  assign prog_output_4_asserted = out4_q;
  assign prog_output_5_asserted = out5_q;

  // checks
  logic [7:0] w_pri4;
  logic [7:0] w_pri5;
  logic [7:0] w_sec4;
  logic [7:0] nv_pri4;
  logic [7:0] wdata_b;
  logic       en4;
  logic       en5;

  assign w_pri4  = work_q[dep_mask_pkg::SLOT_O4_PRI];
  assign w_pri5  = work_q[dep_mask_pkg::SLOT_O5_PRI];
  assign w_sec4  = work_q[dep_mask_pkg::SLOT_O4_SEC];
  assign nv_pri4 = shadow_q[dep_mask_pkg::SLOT_O4_PRI];
  assign wdata_b = hwdata[7:0];
  assign en4     = work_q[dep_mask_pkg::SLOT_MRST][`MRST_BIT_O4];
  assign en5     = work_q[dep_mask_pkg::SLOT_MRST][`MRST_BIT_O5];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_load;
    state_q == dep_mask_pkg::ST_LOAD && !srst;
  endsequence

  sequence s_man_held4;
    (run && en4 && !manual_reset_n) [*3];
  endsequence

  sequence s_man_held5;
    (run && en5 && !manual_reset_n) [*3];
  endsequence

  property p_load_copy;
    s_load |=> run && (w_pri4 == $past(nv_pri4)) && out4_q;
  endproperty
  a_load_copy: assert property (p_load_copy)
    else $error("mask not loaded from shadow");

  property p_nv_write;
    (wr_pend_q && hit_nv[dep_mask_pkg::SLOT_O4_PRI]) |=> nv_pri4 == $past(wdata_b);
  endproperty
  a_nv_write: assert property (p_nv_write)
    else $error("shadow write lost");

  property p_pri4;
    (run && |(w_pri4[5:0] & primary_fault) && !man4) |-> !t42 ##1 (out4_q || $past(prog_output_4_term1));
  endproperty
  a_pri4: assert property (p_pri4)
    else $error("primary fault not seen by out 4 term");

  property p_wdog_sec4;
    (|(w_pri4[7:6] & watchdog_fault) || |(w_sec4[5:0] & secondary_fault)) |-> !t42;
  endproperty
  a_wdog_sec4: assert property (p_wdog_sec4)
    else $error("watchdog or secondary fault ignored");

  property p_empty_term;
    (mask4 == 25'h000_0000) |-> t42;
  endproperty
  a_empty_term: assert property (p_empty_term)
    else $error("empty mask term not one");

  property p_man4;
    s_man_held4 |=> out4_q;
  endproperty
  a_man4: assert property (p_man4)
    else $error("manual reset did not assert out 4");

  property p_man5;
    s_man_held5 |=> out5_q;
  endproperty
  a_man5: assert property (p_man5)
    else $error("manual reset did not assert out 5");

  property p_rel4;
    (run && !man4 && (prog_output_4_term1 || t42)) |=> !out4_q;
  endproperty
  a_rel4: assert property (p_rel4)
    else $error("out 4 not released");

  property p_rel5;
    (run && !man5 && (t51 || prog_output_5_term2)) |=> !out5_q;
  endproperty
  a_rel5: assert property (p_rel5)
    else $error("out 5 not released");

  property p_man_off;
    (run && !en4 && (prog_output_4_term1 || t42)) |=> !out4_q;
  endproperty
  a_man_off: assert property (p_man_off)
    else $error("disabled manual reset still acts");

  property p_pri5;
    (|(w_pri5 & {watchdog_fault, primary_fault})) |-> !t51;
  endproperty
  a_pri5: assert property (p_pri5)
    else $error("out 5 term ignores selected fault");

  property p_read_wait;
    (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer not two edges after address");

endmodule

`default_nettype wire

// ==== verif/ahb_host.sv ====
// AHB-Lite host model issuing single word transfers
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/10ps
`default_nettype none
`include "dep_mask_cfg.svh"
module ahb_host (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `AHB_SIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // call right after a rising edge; only the bench timeout ends a wait
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= `AHB_SIZE_WORD;
    htrans <= 2'b10;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    q = hrdata;
    // released data lines carry no stale value
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== verif/output_dependency_masks_tb.sv ====
// self-checking bench of the output dependency masks
// assumes the host model in ahb_host.sv and the block's config header
`timescale 1ns/10ps
`default_nettype none
`include "dep_mask_cfg.svh"
module output_dependency_masks_tb;
  logic        core_clk;
  logic        srst;
  logic        nv_por;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [5:0]  pri;
  logic [5:0]  sec;
  logic [1:0]  wd;
  logic [3:0]  li;
  logic        mrn;
  logic [5:0]  oth;
  logic        pad;
  logic        t1in;
  logic        t2in;
  logic        out4;
  logic        out5;
  logic [31:0] seed = 32'h0000_0063;
  logic [31:0] q;
  int          num_errors;
  int          total_checks;
  dep_mask_pkg::mask_byte_t m [9];
  localparam logic [15:0] idx_tab [9] = '{`IDX_O4T2_PRI, `IDX_O4T2_SEC, `IDX_O4T2_OUT,
    `IDX_O4T2_O8, `IDX_O5T1_PRI, `IDX_O5T1_SEC, `IDX_O5T1_OUT, `IDX_O5T1_O8, `IDX_MRST_MASK};

  output_dependency_masks uut (
    .core_clk(core_clk), .srst(srst), .nv_por(nv_por), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .primary_fault(pri),
    .secondary_fault(sec), .watchdog_fault(wd), .logic_input(li), .manual_reset_n(mrn),
    .other_output_asserted(oth), .prog_output_4_term1(t1in), .prog_output_5_term2(t2in),
    .prog_output_4_asserted(out4), .prog_output_5_asserted(out5));

  ahb_host host (
    .core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic out5_of(input logic po4);
    return (m[8][`MRST_BIT_O5] & ~mrn) | ~(t2in | (~|({m[6], m[5], m[4]}
      & {oth[4:3], po4, oth[2:0], li, sec, wd, pri}) & ~(m[7][`O8_BIT_O5] & oth[5])));
  endfunction

  // out5 first with po4 low; the bench never links both ways at once
  function automatic logic [1:0] expect_out();
    logic e4;
    logic e5;
    e5 = out5_of(1'b0);
    e4 = (m[8][`MRST_BIT_O4] & ~mrn) | ~(t1in | (~|({m[2], m[1], m[0]}
      & {oth[4:3], e5, oth[2:0], li, sec, wd, pri}) & ~(m[3][`O8_BIT_O4] & oth[5])));
    return {e4, out5_of(e4)};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b1, {14'h0000, i, 2'b00}, {24'h00_0000, d}, r);
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, {14'h0000, i, 2'b00}, 32'h0000_0000, r);
    check("register", r, {24'h00_0000, exp});
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic run_case();
    logic [1:0] e;
    for (int i = 0; i < 9; i++) wr(idx_tab[i], m[i]);
    repeat (4) @(posedge core_clk);
    e = expect_out();
    @(negedge core_clk);
    check("prog_output_4", {31'h0, out4}, {31'h0, e[1]});
    check("prog_output_5", {31'h0, out5}, {31'h0, e[0]});
    @(posedge core_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    {srst, nv_por, mrn} = 3'b111;
    {oth, li, sec, wd, pri, pad, t1in, t2in} = '0;
    m = '{default: 8'h00};
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    check("reset outputs", {30'h0, out4, out5}, 32'h0000_0003);
    @(posedge core_clk);
    srst <= 1'b0;
    nv_por <= 1'b0;
    for (int i = 0; i < 9; i++) rd(idx_tab[i], `REG_RESET);
    // unmapped places read zero and ignore writes
    wr(`IDX_O4T2_PRI, 8'hFF);
    wr(16'h0030, 8'h77);
    rd(16'h0030, 8'h00);
    host.xfer(1'b0, 32'h0004_0080, 32'h0000_0000, r);
    check("high address", r, 32'h0000_0000);
    wr(`NV_BASE | `IDX_O4T2_PRI, 8'hA5);
    wr(`NV_BASE | `IDX_O5T1_PRI, 8'h5A);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rd(`IDX_O4T2_PRI, 8'hA5);
    rd(`IDX_O5T1_PRI, 8'h5A);
    m = '{default: 8'h00};
    mrn <= 1'b0;
    m[8] = 8'h18;
    run_case();
    // status: run, both terms empty, both outputs held, manual reset low
    rd(`IDX_STATUS, 8'h3F);
    m[8] = 8'h00;
    run_case();
    mrn <= 1'b1;
    for (int k = 0; k < 48; k++) begin
      m = '{default: 8'h00};
      {oth[4:3], pad, oth[2:0], li, sec, wd, pri} <= 24'h00_0001 << (k % 24);
      if (k < 24)
        {m[2], m[1], m[0]} = 24'h00_0001 << k;
      else
        {m[6], m[5], m[4]} = 24'h00_0001 << (k - 24);
      run_case();
    end
    // large variant: bits of absent inputs may be set
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 9; i++) m[i] = 8'(rnd() & rnd());
      if (m[2][5])
        m[6][5] = 1'b0;
      r = rnd();
      {oth, li, sec, wd, pri} <= 24'(r & rnd());
      mrn <= r[24];
      t1in <= &r[26:25];
      t2in <= &r[28:27];
      run_case();
      rd(idx_tab[r[31:29]], m[r[31:29]]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
